// ### hdl/igp_gpio.sv
// igp_gpio: 16-pin gpio port with edge interrupts, set/clear masks and
// two bit movers, registers reached over axi4-lite
// assumes: pins are asynchronous to aclk; pin_owner_select is from logic
// on aclk; an external pad combines pin_out with pin_oe_n
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module igp_gpio (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [igp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [igp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe_n,
    // peripheral sharing
    input wire logic [15:0] pin_owner_select,
    input wire logic [15:0] periph_out,
    input wire logic [15:0] periph_oe,
    // interrupt
    output logic irq
);
    // software registers
    logic [15:0] dir_reg; // pin_direction
    logic [15:0] data_output_reg; // data_output
    logic [15:0] fall_reg; // falling_edge_irq_enable
    logic [15:0] rise_reg; // rising_edge_irq_enable
    logic [15:0] pend_reg; // irq_pending_flags
    logic [15:0] pmask_reg; // interrupt mask, one lets a flag through
    logic [15:0] bconf_reg; // bit_mover_config
    // pin synchroniser and history
    logic [15:0] sync1_reg; // first stage, read only by sync2_reg
    logic [15:0] sync2_reg; // pin_input_state
    logic [15:0] prev_reg; // sample one clock older
    // write channel capture
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [igp_pkg::ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic [3:0] wr_idx;
    logic wr_ok;
    logic [15:0] wr_val;
    logic rd_fire;
    logic [3:0] rd_idx;
    logic [15:0] rise_ev;
    logic [15:0] fall_ev;

    // pick bit sel of a 16-bit word
    function automatic logic bit_at(input logic [15:0] v,
                                    input logic [3:0] sel);
        bit_at = v[sel];
    endfunction

    // a word index is mapped when it lies in the eleven decoded slots
    function automatic logic idx_ok(input logic [3:0] idx);
        idx_ok = (idx <= igp_pkg::IDX_LAST);
    endfunction

    // field of the bit-mover config
    function automatic logic [3:0] cfg_nib(input logic [15:0] c,
                                           input int unsigned lsb);
        cfg_nib = c[lsb +: 4];
    endfunction

    // write handshake: address and data taken in either order, held
    // until the response is accepted; one write outstanding at a time.
    // the readies are registered so every port leaves a flip-flop; each
    // looks ahead at what its hold flag and bvalid become at this edge
    assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    assign wr_idx = awaddr_reg[igp_pkg::IDX_LSB +: 4];
    // the own mask word answers okay like the documented ones
    assign wr_ok = (idx_ok(wr_idx) || wr_idx == igp_pkg::IDX_MASK)
                   && (wr_idx != igp_pkg::IDX_PIN_INPUT_STATE);

    // write address ready: low from capture until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_reg
                             && !(s_axi_awvalid && s_axi_awready)
                             && !(s_axi_bvalid && !s_axi_bready);
        end
    end

    // write data ready: same look-ahead on its own hold flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_hold_reg
                            && !(s_axi_wvalid && s_axi_wready)
                            && !(s_axi_bvalid && !s_axi_bready);
        end
    end
    // only the low two byte lanes carry register bits
    assign wr_val = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                     wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};

    // capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
        end
    end

    // capture write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
        end
    end

    // write response; unmapped or read-only word answers slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= igp_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? igp_pkg::RESP_OKAY
                                 : igp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // plain read/write control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_reg <= igp_pkg::REG_RST;
            fall_reg <= igp_pkg::REG_RST;
            rise_reg <= igp_pkg::REG_RST;
            bconf_reg <= igp_pkg::REG_RST;
            pmask_reg <= igp_pkg::REG_RST;
        end else if (wr_fire) begin
            case (wr_idx)
                igp_pkg::IDX_DIR: dir_reg <= wr_val;
                igp_pkg::IDX_FALL: fall_reg <= wr_val;
                igp_pkg::IDX_RISE: rise_reg <= wr_val;
                igp_pkg::IDX_BCONF: bconf_reg <= wr_val;
                igp_pkg::IDX_MASK: pmask_reg <= wr_val; // own mask word
                default: ;
            endcase
        end
    end

    // output data: full write, set mask, clear mask, bit movers.
    // a direction change never touches this register, so polarity can
    // be preset before the pin starts driving
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_output_reg <= igp_pkg::REG_RST;
        end else if (wr_fire) begin
            case (wr_idx)
                igp_pkg::IDX_DATA_OUTPUT: data_output_reg <= wr_val;
                igp_pkg::IDX_SET: data_output_reg <= data_output_reg | wr_val;
                igp_pkg::IDX_CLR: data_output_reg <= data_output_reg & ~wr_val;
                igp_pkg::IDX_BENG0: begin
                    // copy chosen data bit to chosen output bit
                    data_output_reg[cfg_nib(bconf_reg, igp_pkg::BE0_IO_LSB)] <=
                        bit_at(wr_val, cfg_nib(bconf_reg,
                                               igp_pkg::BE0_DAT_LSB));
                end
                igp_pkg::IDX_BENG1: begin
                    data_output_reg[cfg_nib(bconf_reg, igp_pkg::BE1_IO_LSB)] <=
                        bit_at(wr_val, cfg_nib(bconf_reg,
                                               igp_pkg::BE1_DAT_LSB));
                end
                default: ;
            endcase
        end
    end

    // pin synchroniser; two clocks of latency to pin_input_state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= igp_pkg::REG_RST;
            sync2_reg <= igp_pkg::REG_RST;
            prev_reg <= igp_pkg::REG_RST;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // edges seen on synchronised samples, whatever the direction
    assign rise_ev = sync2_reg & ~prev_reg & rise_reg;
    assign fall_ev = ~sync2_reg & prev_reg & fall_reg;

    // pending flags: a new edge wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_reg <= igp_pkg::REG_RST;
        end else if (wr_fire && wr_idx == igp_pkg::IDX_PEND) begin
            pend_reg <= (pend_reg & ~wr_val) | rise_ev | fall_ev;
        end else begin
            pend_reg <= pend_reg | rise_ev | fall_ev;
        end
    end

    // interrupt level, registered so irq comes from a flip-flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pend_reg & pmask_reg);
        end
    end

    // pin drive: owner select picks the source, registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= igp_pkg::REG_RST;
            pin_oe_n <= igp_pkg::OE_N_RST; // every pin released
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (pin_owner_select[i]) begin
                    pin_out[i] <= periph_out[i];
                    pin_oe_n[i] <= ~periph_oe[i];
                end else begin
                    pin_out[i] <= data_output_reg[i];
                    pin_oe_n[i] <= ~dir_reg[i];
                end
            end
        end
    end

    // read channel: one read at a time, answer one cycle after address
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign rd_idx = s_axi_araddr[igp_pkg::IDX_LSB +: 4];

    // read address ready, registered: drops with the address taken and
    // comes back at the edge that retires the read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !rd_fire && !(s_axi_rvalid && !s_axi_rready);
        end
    end

    // read data mux; upper sixteen bits read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= igp_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= idx_ok(rd_idx) || rd_idx == igp_pkg::IDX_MASK
                           ? igp_pkg::RESP_OKAY : igp_pkg::RESP_SLVERR;
            case (rd_idx)
                igp_pkg::IDX_DIR: s_axi_rdata <= {16'h0000, dir_reg};
                igp_pkg::IDX_DATA_OUTPUT:
                    s_axi_rdata <= {16'h0000, data_output_reg};
                igp_pkg::IDX_PIN_INPUT_STATE:
                    s_axi_rdata <= {16'h0000, sync2_reg};
                igp_pkg::IDX_FALL: s_axi_rdata <= {16'h0000, fall_reg};
                igp_pkg::IDX_RISE: s_axi_rdata <= {16'h0000, rise_reg};
                igp_pkg::IDX_PEND: s_axi_rdata <= {16'h0000, pend_reg};
                igp_pkg::IDX_BCONF: s_axi_rdata <= {16'h0000, bconf_reg};
                igp_pkg::IDX_BENG0: begin
                    // chosen pin bit lands at chosen data bit
                    s_axi_rdata <= {16'h0000,
                        16'(bit_at(sync2_reg, cfg_nib(bconf_reg,
                            igp_pkg::BE0_IO_LSB)))
                        << cfg_nib(bconf_reg, igp_pkg::BE0_DAT_LSB)};
                end
                igp_pkg::IDX_BENG1: begin
                    s_axi_rdata <= {16'h0000,
                        16'(bit_at(sync2_reg, cfg_nib(bconf_reg,
                            igp_pkg::BE1_IO_LSB)))
                        << cfg_nib(bconf_reg, igp_pkg::BE1_DAT_LSB)};
                end
                igp_pkg::IDX_MASK: s_axi_rdata <= {16'h0000, pmask_reg};
                default: s_axi_rdata <= 32'h0000_0000; // set/clear masks and unmapped words read zero
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks beside the logic
    a_dir_reset: assert property (@(posedge aclk)
        !aresetn |=> dir_reg == 16'h0000)
        else $error("direction not cleared by reset");
    a_set_or: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_idx == igp_pkg::IDX_SET
        |=> data_output_reg == ($past(data_output_reg) | $past(wr_val)))
        else $error("set mask did not or into output");
    a_clr_and: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_idx == igp_pkg::IDX_CLR
        |=> data_output_reg == ($past(data_output_reg) & ~$past(wr_val)))
        else $error("clear mask did not clear output");
    a_dir_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_idx == igp_pkg::IDX_DIR |=> $stable(data_output_reg))
        else $error("direction write changed output data");
    a_rise_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        (rise_ev[0] | fall_ev[0]) |=> pend_reg[0])
        else $error("enabled edge did not set pending");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        |(pend_reg & pmask_reg) |=> irq)
        else $error("irq low while unmasked flag pending");
    a_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_owner_select[0] |=> pin_oe_n[0] == !$past(dir_reg[0]))
        else $error("pin enable does not follow direction");
    a_owner_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_owner_select[1] |=> pin_out[1] == $past(periph_out[1]))
        else $error("peripheral output not routed");
    a_pin_input_state_lat: assert property (@(posedge aclk) disable iff (!aresetn)
        ##2 sync2_reg == $past(pin_in, 2))
        else $error("input state latency wrong");
    a_edge_once: assert property (@(posedge aclk) disable iff (!aresetn)
        rise_ev[2] |=> !rise_ev[2])
        else $error("one edge raised two events");
    c_write: cover property (@(posedge aclk) wr_fire);
    c_read: cover property (@(posedge aclk) rd_fire);
    c_irq: cover property (@(posedge aclk) $rose(irq));
    c_clear_set: cover property (@(posedge aclk)
        wr_fire && wr_idx == igp_pkg::IDX_PEND && |rise_ev);
endmodule // igp_gpio
`default_nettype wire

// ### hdl/igp_pkg.sv
// igp_pkg: constants for the interrupt-capable 16-bit gpio port
// assumes: an axi4-lite slave with 32-bit data, one word per register
package igp_pkg;
    // port width
    localparam int unsigned PIN_W = 16;
    // register indices (word offsets)
    localparam logic [3:0] IDX_DIR = 4'h0;
    localparam logic [3:0] IDX_DATA_OUTPUT = 4'h1;
    localparam logic [3:0] IDX_PIN_INPUT_STATE = 4'h2;
    localparam logic [3:0] IDX_FALL = 4'h3;
    localparam logic [3:0] IDX_RISE = 4'h4;
    localparam logic [3:0] IDX_PEND = 4'h5;
    localparam logic [3:0] IDX_SET = 4'h6;
    localparam logic [3:0] IDX_CLR = 4'h7;
    localparam logic [3:0] IDX_BCONF = 4'h8;
    localparam logic [3:0] IDX_BENG0 = 4'h9;
    localparam logic [3:0] IDX_BENG1 = 4'hA;
    localparam logic [3:0] IDX_LAST = 4'hA;
    // own interrupt mask word, just past the eleven documented ones
    localparam logic [3:0] IDX_MASK = 4'hB;
    // byte address field inside awaddr/araddr
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned IDX_LSB = 2;
    // reset value of every register except pin_oe_n
    localparam logic [15:0] REG_RST = 16'h0000;
    // pins start released: active-low output enables all high
    localparam logic [15:0] OE_N_RST = 16'hFFFF;
    // bit-mover config field positions
    localparam int unsigned BE0_IO_LSB = 0;
    localparam int unsigned BE0_DAT_LSB = 4;
    localparam int unsigned BE1_IO_LSB = 8;
    localparam int unsigned BE1_DAT_LSB = 12;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : igp_pkg

// ### verification/igp_pins_model.sv
// igp_pins_model: pads of the port, board pull-ups and an outside driver
// assumes: pin_oe_n low means the port drives; outside driver wins a clash
`timescale 1ns/100ps
`default_nettype none
module igp_pins_model (
    // port side
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    // outside driver, commanded by the bench
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    // resolved line level
    output logic [15:0] pin_level
);
    // each line: outside driver, else port, else pull-up
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else
                pin_level[i] = 1'b1; // released line floats high
        end
    end
endmodule // igp_pins_model
`default_nettype wire

// ### verification/tb_top.sv
// tb_top: self-checking bench for the gpio port over axi4-lite
// assumes: igp_gpio and igp_pins_model compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic aclk, aresetn;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, irq;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] pin_out, pin_oe_n, pin_level, pin_owner_select;
    logic [15:0] periph_out, periph_oe, ext_en, ext_val;
    logic [15:0] d, o, m;
    logic [31:0] seed = 32'h0BFD;
    logic [33:0] exp_q[$]; // expected read {resp, data}
    logic [33:0] e;
    int failures = 0;
    int samples_checked = 0;
    localparam logic [1:0] OK = igp_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = igp_pkg::RESP_SLVERR;

    igp_gpio i_igp_gpio (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in(pin_level),
        .pin_out, .pin_oe_n, .pin_owner_select, .periph_out, .periph_oe,
        .irq);
    igp_pins_model i_igp_pins_model (.pin_out, .pin_oe_n, .ext_en,
        .ext_val, .pin_level);

    // clock, 4 ns period
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // galois-free shift register for stimulus values
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [33:0] s, x);
        samples_checked++;
        if (s !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask

    // ready and valid are settled by the falling edge: sample them
    // there, and release at the following rising edge
    task automatic wr(input logic [5:0] a, input logic [15:0] v,
                      input logic [1:0] er);
        logic ta, tw, tb, done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                check("bresp", 34'(s_axi_bresp), 34'(er));
                done = 1'b1;
            end
        end
        if (!done) failures++;
    endtask

    // read: the expectation is queued, the monitor compares it
    task automatic rd(input logic [5:0] a, input logic [15:0] v,
                      input logic [1:0] er);
        logic ta, tr, done;
        done = 1'b0;
        exp_q.push_back({er, 16'h0000, v});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            done = tr;
        end
        if (!done) failures++;
    endtask

    // monitor: each accepted read beat takes the oldest expectation
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e = exp_q.pop_front();
            check("rdata", {s_axi_rresp, s_axi_rdata}, e);
        end
    end

    task automatic settle(input int n);
        repeat (n) @(negedge aclk);
    endtask

    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    initial begin
        aresetn <= 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
        {s_axi_arvalid, s_axi_rready} <= 2'h0;
        s_axi_awaddr <= 6'h00;
        s_axi_araddr <= 6'h00;
        s_axi_wdata <= 32'h0000_0000;
        s_axi_wstrb <= 4'hF;
        pin_owner_select <= 16'h0000;
        periph_out <= 16'h0000;
        periph_oe <= 16'h0000;
        ext_en <= 16'hFFFF; // pins held low so input state reads zero
        ext_val <= 16'h0000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 11; i++) rd(6'(i * 4), 16'h0000, OK);
        rd(6'h30, 16'h0000, ERR);
        check("oe_rst", 34'(pin_oe_n), 34'(16'hFFFF));
        ext_en <= 16'h0000;
        seed = lfsr(seed);
        d = seed[15:0];
        wr(6'h00, d, OK);
        rd(6'h00, d, OK);
        seed = lfsr(seed);
        o = seed[15:0];
        wr(6'h04, o, OK);
        rd(6'h04, o, OK);
        settle(4);
        check("pins", 34'(pin_level),
              34'(16'((d & o) | ~d)));
        check("oe_n", 34'(pin_oe_n), 34'(16'(~d)));
        rd(6'h08, (d & o) | ~d, OK);
        wr(6'h08, 16'h1234, ERR);
        seed = lfsr(seed);
        m = seed[15:0];
        wr(6'h18, m, OK);
        o = o | m;
        rd(6'h04, o, OK);
        seed = lfsr(seed);
        m = seed[15:0];
        wr(6'h1C, m, OK);
        rd(6'h04, o & ~m, OK);
        wr(6'h04, 16'hFFFF, OK);
        wr(6'h00, 16'h0000, OK);
        wr(6'h00, 16'hFFFF, OK);
        settle(3);
        check("r8_out", 34'(pin_out), 34'(16'hFFFF));
        check("r8_oe", 34'(pin_oe_n), 34'(16'h0000));
        seed = lfsr(seed);
        m = seed[15:0];
        @(posedge aclk);
        pin_owner_select <= m;
        periph_out <= seed[31:16];
        periph_oe <= seed[23:8];
        settle(3);
        check("own_out", 34'(pin_out),
              34'(16'((m & seed[31:16]) | ~m)));
        check("own_oe", 34'(pin_oe_n),
              34'(16'(~((m & seed[23:8]) | ~m))));
        @(posedge aclk);
        pin_owner_select <= 16'h0000;
        wr(6'h00, 16'h0000, OK);
        ext_en <= 16'hFFFF;
        wr(6'h2C, 16'hFFFF, OK);
        wr(6'h0C, 16'h00F0, OK);
        wr(6'h10, 16'h000F, OK);
        rd(6'h0C, 16'h00F0, OK);
        rd(6'h10, 16'h000F, OK);
        ext_val <= 16'h00FF;
        settle(6);
        rd(6'h14, 16'h000F, OK);
        check("irq_on", 34'(irq), 34'(1'b1));
        ext_val <= 16'h0200;
        settle(6);
        rd(6'h14, 16'h00FF, OK);
        wr(6'h14, 16'h0005, OK);
        rd(6'h14, 16'h00FA, OK);
        wr(6'h2C, 16'h0000, OK);
        settle(3);
        check("irq_mask", 34'(irq), 34'(1'b0));
        wr(6'h2C, 16'hFFFF, OK);
        wr(6'h14, 16'hFFFF, OK);
        settle(3);
        check("irq_clr", 34'(irq), 34'(1'b0));
        wr(6'h04, 16'h0000, OK);
        wr(6'h20, 16'h7925, OK);
        wr(6'h24, 16'h0004, OK);
        rd(6'h04, 16'h0020, OK);
        rd(6'h28, 16'h0080, OK);
        rd(6'h20, 16'h7925, OK);
        settle(4);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
